// ==== rtl/rxtps_rx_stream.v ====
`timescale 1ns/10ps
`default_nettype none
`include "rxtps_defs.vh"

module rxtps_rx_stream #(
	parameter DATA_W = `RXTPS_W128,
	parameter NP_AW  = 4,
	parameter REQ_W  = 6
) (
	input  wire              i_ref_clk,
	input  wire              i_sys_rst,
	input  wire              i_link_reset,
	input  wire              i_in_valid,
	output wire              o_in_ready,
	input  wire [DATA_W-1:0] i_in_data,
	input  wire              i_in_sof,
	input  wire              i_in_eof,
	input  wire [1:0]        i_in_rem,
	input  wire              i_in_nonposted,
	output wire [DATA_W-1:0] o_rx_packet_data,
	output wire              o_rx_start_of_frame,
	output wire              o_rx_end_of_frame,
	output wire [1:0]        o_rx_word_remainder,
	output wire              o_rx_source_ready,
	output wire              o_rx_source_discontinue,
	input  wire              i_rx_destination_ready,
	input  wire              i_rx_nonposted_ok,
	input  wire              i_rx_nonposted_request
);

	localparam BW       = DATA_W + `RXTPS_B_SIDE;
	localparam NP_DEPTH = 1 << NP_AW;
	// Counter constants built at their own widths so nothing is truncated
	localparam [NP_AW:0] NP_FULL  = {1'b1, {NP_AW{1'b0}}};
	localparam [NP_AW:0] NP_NONE  = {(NP_AW+1){1'b0}};
	localparam [NP_AW:0] NP_STEP  = {{NP_AW{1'b0}}, 1'b1};
	localparam [REQ_W-1:0] RQ_NONE = {REQ_W{1'b0}};
	localparam [REQ_W-1:0] RQ_STEP = {{(REQ_W-1){1'b0}}, 1'b1};
	localparam [REQ_W-1:0] RQ_MAX  = {REQ_W{1'b1}};

	// Remainder bits outside their valid beat are driven low
	function [1:0] rem_fix;
		input [1:0] r;
		input       s;
		input       e;
		begin
			rem_fix[1] = (DATA_W == `RXTPS_W128) & (s | e) & r[1];
			rem_fix[0] = e & r[0];
		end
	endfunction

	function [NP_AW-1:0] ptr_next;
		input [NP_AW-1:0] p;
		begin
			ptr_next = p + {{(NP_AW-1){1'b0}}, 1'b1};
		end
	endfunction

	reg [`RXTPS_ST_W-1:0] st_q;
	reg [`RXTPS_ST_W-1:0] st_d;
	reg [BW-1:0]          np_mem [0:NP_DEPTH-1];
	reg [NP_AW-1:0]       wr_q;
	reg [NP_AW-1:0]       rd_q;
	reg [NP_AW:0]         np_cnt_q;
	reg [NP_AW:0]         np_cnt_d;
	reg [BW-1:0]          b0_q;
	reg [BW-1:0]          b1_q;
	reg [`RXTPS_BC_W-1:0] bc_q;
	reg [REQ_W-1:0]       rq_q;
	reg [REQ_W-1:0]       rq_d;
	reg                   dsc_q;
	reg [BW-1:0]          new_beat;

	wire          st_idle;
	wire          st_pc;
	wire          st_np;
	wire          np_empty;
	wire          np_full;
	wire [BW-1:0] np_head;
	wire          np_head_sof;
	wire          buf_acc;
	wire          np_wr;
	wire          np_start;
	wire          np_drop;
	wire          np_push;
	wire          np_pop;
	wire          pc_start;
	wire          pc_push;
	wire          push;
	wire          pop;
	wire          push_eof;
	wire [BW-1:0] in_beat;

	assign st_idle     = (st_q == `RXTPS_ST_IDLE);
	assign st_pc       = (st_q == `RXTPS_ST_PC);
	assign st_np       = (st_q == `RXTPS_ST_NP);
	assign np_empty    = (np_cnt_q == NP_NONE);
	assign np_full     = (np_cnt_q == NP_FULL);
	assign np_head     = np_mem[rd_q];
	assign np_head_sof = np_head[`RXTPS_B_SOF];
	assign buf_acc     = (bc_q != `RXTPS_BC_FULL);

	assign in_beat = {i_in_data, i_in_rem, i_in_eof, i_in_sof};

	// Ingress: non-posted beats queue whenever there is room, others only pass while a
	// posted/completion packet owns the output. During link reset all
	// ingress is swallowed so the upstream side can flush too.
	assign o_in_ready = i_link_reset |
		(i_in_nonposted ? ~np_full : ((st_pc & buf_acc) | (st_idle & ~i_in_sof)));

	assign np_wr = i_in_valid & i_in_nonposted & ~np_full & ~i_link_reset;

	// A non-posted packet starts only when the user has both opened the
	// gate and left an outstanding request for it.
	assign np_start = st_idle & ~np_empty & np_head_sof & i_rx_nonposted_ok
		& (rq_q != RQ_NONE) & ~i_link_reset;
	// Stray beats with no frame start are discarded rather than wedging
	assign np_drop  = st_idle & ~np_empty & ~np_head_sof & ~i_link_reset;
	assign pc_start = st_idle & ~np_start & i_in_valid & ~i_in_nonposted
		& i_in_sof & ~i_link_reset;

	assign np_push = st_np & ~np_empty & buf_acc & ~i_link_reset;
	assign pc_push = st_pc & i_in_valid & ~i_in_nonposted & buf_acc & ~i_link_reset;
	assign np_pop  = np_push | np_drop;
	assign push    = np_push | pc_push;
	assign pop     = o_rx_source_ready & i_rx_destination_ready;

	always @* begin
		if (st_np) begin
			new_beat = np_head;
		end else begin
			new_beat = in_beat;
		end
		new_beat[`RXTPS_B_REM_HI:`RXTPS_B_REM_LO] = rem_fix(
			new_beat[`RXTPS_B_REM_HI:`RXTPS_B_REM_LO],
			new_beat[`RXTPS_B_SOF], new_beat[`RXTPS_B_EOF]);
	end

	assign push_eof = new_beat[`RXTPS_B_EOF];

	// Arbiter: one bubble between packets keeps the start decision off
	// the data path, at the cost of a cycle per packet.
	always @* begin
		st_d = st_q;
		case (st_q)
			`RXTPS_ST_IDLE: begin
				if (np_start) begin
					st_d = `RXTPS_ST_NP;
				end else if (pc_start) begin
					st_d = `RXTPS_ST_PC;
				end
			end
			`RXTPS_ST_PC: begin
				if (pc_push & push_eof) begin
					st_d = `RXTPS_ST_IDLE;
				end
			end
			`RXTPS_ST_NP: begin
				if (np_push & push_eof) begin
					st_d = `RXTPS_ST_IDLE;
				end
			end
			default: begin
				st_d = `RXTPS_ST_IDLE;
			end
		endcase
		if (i_link_reset) begin
			st_d = `RXTPS_ST_IDLE;
		end
	end

	always @* begin
		np_cnt_d = np_cnt_q;
		if (np_wr & ~np_pop) begin
			np_cnt_d = np_cnt_q + NP_STEP;
		end else if (~np_wr & np_pop) begin
			np_cnt_d = np_cnt_q - NP_STEP;
		end
		if (i_link_reset) begin
			np_cnt_d = NP_NONE;
		end
	end

	// Saturation keeps a request line stuck high from wrapping the count
	// back to zero and silently losing every outstanding grant.
	// Requests survive link reset; they belong to the user side
	always @* begin
		rq_d = rq_q;
		if (i_rx_nonposted_request & ~np_start & (rq_q != RQ_MAX)) begin
			rq_d = rq_q + RQ_STEP;
		end else if (~i_rx_nonposted_request & np_start) begin
			rq_d = rq_q - RQ_STEP;
		end
	end

	always @(posedge i_ref_clk) begin
		if (np_wr) begin
			np_mem[wr_q] <= in_beat;
		end
	end

	always @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q     <= `RXTPS_ST_IDLE;
			wr_q     <= {NP_AW{1'b0}};
			rd_q     <= {NP_AW{1'b0}};
			np_cnt_q <= NP_NONE;
			rq_q     <= RQ_NONE;
		end else begin
			st_q     <= st_d;
			np_cnt_q <= np_cnt_d;
			rq_q     <= rq_d;
			if (i_link_reset) begin
				wr_q <= {NP_AW{1'b0}};
				rd_q <= {NP_AW{1'b0}};
			end else begin
				if (np_wr) begin
					wr_q <= ptr_next(wr_q);
				end
				if (np_pop) begin
					rd_q <= ptr_next(rd_q);
				end
			end
		end
	end

	// Two-entry output buffer: b0 is what the user sees. A stall by the
	// user leaves the pushed beat in b1, so no beat is lost.
	always @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			b0_q <= {BW{1'b0}};
			b1_q <= {BW{1'b0}};
			bc_q <= `RXTPS_BC_EMPTY;
		end else if (i_link_reset) begin
			bc_q <= `RXTPS_BC_EMPTY;
		end else begin
			case ({push, pop})
				2'h3: begin
					if (bc_q == `RXTPS_BC_ONE) begin
						b0_q <= new_beat;
					end else begin
						b0_q <= b1_q;
						b1_q <= new_beat;
					end
				end
				2'h2: begin
					if (bc_q == `RXTPS_BC_EMPTY) begin
						b0_q <= new_beat;
						bc_q <= `RXTPS_BC_ONE;
					end else begin
						b1_q <= new_beat;
						bc_q <= `RXTPS_BC_FULL;
					end
				end
				2'h1: begin
					b0_q <= b1_q;
					bc_q <= bc_q - `RXTPS_BC_ONE;
				end
				default: begin
					bc_q <= bc_q;
				end
			endcase
		end
	end

	// Discontinue is a level one edge behind link reset, whether or not a
	// packet was open; the user must drop any partial packet it holds.
	always @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dsc_q <= 1'b0;
		end else begin
			dsc_q <= i_link_reset;
		end
	end

	// Ready drops in the link reset cycle itself so no stale beat slips out
	assign o_rx_source_ready       = (bc_q != `RXTPS_BC_EMPTY) & ~i_link_reset;
	assign o_rx_packet_data        = b0_q[BW-1:`RXTPS_B_DATA];
	assign o_rx_start_of_frame     = b0_q[`RXTPS_B_SOF];
	assign o_rx_end_of_frame       = b0_q[`RXTPS_B_EOF];
	assign o_rx_word_remainder     = b0_q[`RXTPS_B_REM_HI:`RXTPS_B_REM_LO];
	assign o_rx_source_discontinue = dsc_q;

endmodule // rxtps_rx_stream

`default_nettype wire

// ==== rtl/rxtps_defs.vh ====
`ifndef RXTPS_DEFS_VH
`define RXTPS_DEFS_VH

// Datapath widths the remainder encoding knows
`define RXTPS_W64       64
`define RXTPS_W128      128

// Packed beat layout: {data, rem[1:0], eof, sof}
`define RXTPS_B_SOF     0
`define RXTPS_B_EOF     1
`define RXTPS_B_REM_LO  2
`define RXTPS_B_REM_HI  3
`define RXTPS_B_DATA    4
`define RXTPS_B_SIDE    4

// Arbiter states, one-hot
`define RXTPS_ST_W      3
`define RXTPS_ST_IDLE   3'h1
`define RXTPS_ST_PC     3'h2
`define RXTPS_ST_NP     3'h4

// Output buffer occupancy
`define RXTPS_BC_W      2
`define RXTPS_BC_EMPTY  2'h0
`define RXTPS_BC_ONE    2'h1
`define RXTPS_BC_FULL   2'h2

`endif

// ==== bench/rxtps_rx_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module rxtps_rx_mon #(parameter DATA_W = 128) (
	input wire logic              i_ref_clk,
	input wire logic              i_sys_rst,
	input wire logic              i_link_reset,
	input wire logic              i_rx_destination_ready,
	input wire logic [DATA_W-1:0] o_rx_packet_data,
	input wire logic              o_rx_start_of_frame,
	input wire logic              o_rx_end_of_frame,
	input wire logic [1:0]        o_rx_word_remainder,
	input wire logic              o_rx_source_ready,
	input wire logic              o_rx_source_discontinue
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	logic open_q;
	wire  take = o_rx_source_ready && i_rx_destination_ready;
	// A link flush drops any open packet, so the next beat starts afresh
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
		if (i_sys_rst) open_q <= 1'b0;
		else if (i_link_reset) open_q <= 1'b0;
		else if (take) open_q <= !o_rx_end_of_frame;
	a_srdy_in_flush: assert property (i_link_reset |-> !o_rx_source_ready)
		else $error("source ready during link reset");
	a_dsc_on_flush: assert property ($rose(i_link_reset) |=> o_rx_source_discontinue)
		else $error("discontinue missing");
	a_dsc_after: assert property ($fell(i_link_reset) |=> !o_rx_source_discontinue)
		else $error("discontinue stuck");
	a_hold_stall: assert property (o_rx_source_ready && !i_rx_destination_ready ##1 !i_link_reset
		|-> o_rx_source_ready && $stable(o_rx_packet_data) && $stable(o_rx_end_of_frame))
		else $error("beat lost in stall");
	a_rem_hi_idle: assert property (o_rx_source_ready && !o_rx_start_of_frame && !o_rx_end_of_frame
		|-> !o_rx_word_remainder[1])
		else $error("upper remainder outside frame edge");
	a_rem_lo_eof: assert property (o_rx_source_ready && !o_rx_end_of_frame
		|-> !o_rx_word_remainder[0])
		else $error("lower remainder without eof");
	a_sof_first: assert property (o_rx_source_ready && !open_q |-> o_rx_start_of_frame)
		else $error("first beat lacks sof");
	a_sof_inner: assert property (o_rx_source_ready && open_q |-> !o_rx_start_of_frame)
		else $error("sof inside open packet");
endmodule // rxtps_rx_mon
bind rxtps_rx_stream rxtps_rx_mon #(.DATA_W(DATA_W)) u_mon (.i_ref_clk, .i_sys_rst,
	.i_link_reset, .i_rx_destination_ready, .o_rx_packet_data, .o_rx_start_of_frame,
	.o_rx_end_of_frame, .o_rx_word_remainder, .o_rx_source_ready, .o_rx_source_discontinue);
`default_nettype wire

// ==== bench/rxtps_user_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module rxtps_user_model (
	input wire logic       i_ref_clk,
	input wire logic       i_sys_rst,
	input wire logic [1:0] i_mode,
	input wire logic       i_ok,
	input wire logic       i_req,
	output var logic       o_rdy,
	output var logic       o_ok,
	output var logic       o_req
);
	logic [15:0] lf_q;
	// Mode 0 takes every beat, 1 stalls at random, 2 stalls until told
	always_ff @(posedge i_ref_clk or posedge i_sys_rst)
		if (i_sys_rst) begin
			lf_q <= 16'h10DB;
			o_rdy <= 1'b0;
			o_ok <= 1'b0;
			o_req <= 1'b0;
		end else begin
			lf_q <= {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
			o_rdy <= i_mode == 2'h0 || (i_mode == 2'h1 && lf_q[0]);
			o_ok <= i_ok;
			o_req <= i_req;
		end
endmodule // rxtps_user_model
`default_nettype wire

// ==== bench/rxtps_rx_stream_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module rxtps_rx_stream_test;
	logic clk = 0, rst = 1, lrst = 0, vld = 0, sof = 0, eof = 0, np = 0, ok = 1, req = 0;
	logic [127:0] dat = 0;
	logic [1:0] rem = 0, mode = 0;
	logic [31:0] seed = 4315;
	wire in_rdy, srdy, dsc, drdy, npok, npreq, osof, oeof;
	wire [127:0] odat;
	wire [1:0] orem;
	wire in_rdy_n, srdy_n, dsc_n, osof_n, oeof_n;
	wire [63:0] odat_n;
	wire [1:0] orem_n;
	logic [131:0] got;
	int lens[5] = '{1, 2, 3, 5, 1};
	logic [131:0] exp_q[$], npq[$];
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	rxtps_rx_stream #(.DATA_W(128)) dut_u (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_link_reset(lrst), .i_in_valid(vld), .o_in_ready(in_rdy), .i_in_data(dat),
		.i_in_sof(sof), .i_in_eof(eof), .i_in_rem(rem), .i_in_nonposted(np),
		.o_rx_packet_data(odat), .o_rx_start_of_frame(osof), .o_rx_end_of_frame(oeof),
		.o_rx_word_remainder(orem), .o_rx_source_ready(srdy), .o_rx_source_discontinue(dsc),
		.i_rx_destination_ready(drdy), .i_rx_nonposted_ok(npok), .i_rx_nonposted_request(npreq));
	// Same traffic through a 64-bit build exercises the narrow remainder
	rxtps_rx_stream #(.DATA_W(64)) dut_w64_u (.i_ref_clk(clk), .i_sys_rst(rst),
		.i_link_reset(lrst), .i_in_valid(vld), .o_in_ready(in_rdy_n), .i_in_data(dat[63:0]),
		.i_in_sof(sof), .i_in_eof(eof), .i_in_rem(rem), .i_in_nonposted(np),
		.o_rx_packet_data(odat_n), .o_rx_start_of_frame(osof_n), .o_rx_end_of_frame(oeof_n),
		.o_rx_word_remainder(orem_n), .o_rx_source_ready(srdy_n),
		.o_rx_source_discontinue(dsc_n), .i_rx_destination_ready(drdy),
		.i_rx_nonposted_ok(npok), .i_rx_nonposted_request(npreq));
	rxtps_user_model user_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_mode(mode), .i_ok(ok),
		.i_req(req), .o_rdy(drdy), .o_ok(npok), .o_req(npreq));
	initial forever #2.5 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [131:0] e, input logic [131:0] a);
		checks_done++;
		if (a !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, a);
		end
	endtask
	task automatic summarize;
		if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic send(input int len, input logic n);
		logic s, e;
		for (int i = 0; i < len; i++) begin
			seed = lfsr(seed);
			s = i == 0;
			e = i == len - 1;
			{dat, vld, sof, eof, rem, np} <= {{4{seed}}, 1'b1, s, e, seed[1:0], n};
			if (n) npq.push_back({{4{seed}}, seed[1] & (s | e), seed[0] & e, e, s});
			else exp_q.push_back({{4{seed}}, seed[1] & (s | e), seed[0] & e, e, s});
			@(negedge clk);
			while (!in_rdy || !in_rdy_n) @(negedge clk);
			@(posedge clk);
		end
		vld <= 1'b0;
		@(posedge clk);
	endtask
	task automatic drain;
		for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk("beats left", 0, exp_q.size());
	endtask
	// Grant one request and expect exactly the oldest queued packet
	task automatic grant;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		do exp_q.push_back(npq.pop_front()); while (!exp_q[$][1]);
	endtask
	always @(posedge clk) if (!rst && srdy && drdy) begin
		if (exp_q.size() == 0) chk("stray beat", 0, 1);
		else begin
			got = exp_q.pop_front();
			chk("beat", got, {odat, orem, oeof, osof});
			chk("narrow ready", 1, srdy_n);
			chk("narrow beat", {got[67:4], 1'b0, got[2:0]}, {odat_n, orem_n, oeof_n, osof_n});
		end
	end
	always @(posedge clk) if (++cyc == 20000) begin
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			mode <= m[1:0];
			foreach (lens[k]) send(lens[k], 1'b0);
			drain();
		end
		ok <= 1'b0;
		send(3, 1'b1);
		send(2, 1'b0);
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		drain();
		do exp_q.push_back(npq.pop_front()); while (!exp_q[$][1]);
		ok <= 1'b1;
		drain();
		send(2, 1'b1);
		send(1, 1'b1);
		grant();
		drain();
		grant();
		drain();
		mode <= 2'h2;
		send(2, 1'b0);
		repeat (3) @(posedge clk);
		lrst <= 1'b1;
		exp_q.delete();
		repeat (3) @(negedge clk);
		chk("discontinue", 1, dsc);
		chk("narrow discontinue", 1, dsc_n);
		chk("source ready", 0, srdy);
		@(posedge clk);
		lrst <= 1'b0;
		mode <= 2'h0;
		repeat (2) @(negedge clk);
		chk("discontinue", 0, dsc);
		chk("narrow discontinue", 0, dsc_n);
		chk("flushed", 0, srdy);
		@(posedge clk);
		send(2, 1'b0);
		drain();
		summarize();
	end
endmodule // rxtps_rx_stream_test
`default_nettype wire
